/* wrc_pkg.sv */
// Purpose: shared constants and types for the wake and reset control block
// Assumes: 250 MHz clock, register port with one-cycle read latency
// Notes:   all offsets and counts live here, with the option and prescale reset values
package wrc_pkg;

  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned DRT_RC_US      = 1000;
  localparam int unsigned DRT_STD_US     = 18000;
  localparam int unsigned DRT_RC_CYC     = DRT_RC_US * CLK_MHZ;
  localparam int unsigned DRT_STD_CYC    = DRT_STD_US * CLK_MHZ;
  localparam int unsigned FILT_CYC       = 4;

  localparam logic [3:0] OFS_SECOND_OPTION_REGISTER     = 4'h0;
  localparam logic [3:0] OFS_STATUS      = 4'h1;
  localparam logic [3:0] OFS_TIMER       = 4'h2;
  localparam logic [3:0] OFS_PRESCALE    = 4'h3;
  localparam logic [3:0] OFS_CONTROL     = 4'h4;

  localparam int unsigned OPT_SL_BIT     = 1;
  localparam int unsigned OPT_PCW_BIT    = 2;
  localparam int unsigned OPT_BOD_BIT    = 3;
  localparam int unsigned OPT_SWDT_BIT   = 4;

  localparam logic [7:0] SECOND_OPTION_REGISTER_RST     = 8'h08;
  localparam logic [2:0] PRESCALE_RST    = 3'h0;
  localparam logic [3:0] FIRST_SHIFT     = 4'h3;

  typedef enum logic [1:0] {
    WRC_RUN   = 2'b00,
    WRC_SLEEP = 2'b01,
    WRC_HOLD  = 2'b10
  } wrc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wrc_req_t;

  typedef struct packed {
    logic oscillator_select_hi;
    logic oscillator_select_lo;
    logic wdt_fuse;
  } wrc_cfg_t;

endpackage : wrc_pkg

/* wrc_top.sv */
// Purpose: sleep, wake, brown-out and reset control with clock output
// Assumes: pins synchronous to clock; config word static
// Notes:   reset source shown in status; core reset is core_reset_n
//
// Behaviour
// R1: capture five wake pin levels at sleep
// R2: wake only on opposite level to captured
// R3: wake acts through a warm reset
// R4: pin-change wake clears wake flag
// R5: bit seven pin also wakes, same flag
// R6: one enable arms all five wake inputs
// R7: enabled brown-out holds core in reset
// R8: brown-out off at power-up, enable active low
// R9: watchdog on when fuse set
// R10: watchdog enable latched at sleep entry
// R11: software bit four controls watchdog without fuse
// R12: software watchdog enable starts disabled
// R13: rc mode start-up 1 ms not 18 ms
// R14: short delay after every reset source
// R15: sleep low voltage bit lowers core supply
// R16: glitch filter wake pins and reset pin
// R17: rc mode clock output from timer bit zero
// R18: prescaler selects clock divide 4 to 512
// R19: software timer bit zero drives clock output
// R20: wake armed only asleep and enabled
`timescale 1ns/1ps
module wrc_top
  import wrc_pkg::*;
#(
  parameter int unsigned DRT_RC  = DRT_RC_CYC,
  parameter int unsigned DRT_STD = DRT_STD_CYC,
  parameter int unsigned FILT    = FILT_CYC
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire wrc_req_t   req,
  output logic [7:0]      rdata,
  input  wire wrc_cfg_t   cfg,
  input  wire logic       sleep_req,
  input  wire logic [3:0] wake_pins,
  input  wire logic       wake_slow_pin,
  input  wire logic       external_reset_pin_n,
  input  wire logic       brownout_detect,
  input  wire logic       watchdog_timeout,
  output logic            core_reset_n,
  output logic            asleep,
  output logic            watchdog_enable,
  output logic            sleep_low_voltage_select,
  output logic            clock_output_pin
);

  ////////////////////////////////////////////////////////////////////////////
  wrc_state_t  state_q;
  logic [7:0]  second_option_register_q;
  logic        pin_change_wake_flag_q;
  logic        wdt_cause_q;
  logic [7:0]  timer_zero_register_q;
  logic [2:0]  prescale_q;
  logic [9:0]  pre_cnt_q;
  logic [4:0]  wake_lat_q;
  logic [4:0]  wake_flt_q;
  logic        external_reset_pin_flt_q;
  logic        wdt_lat_q;
  logic [31:0] drt_cnt_q;
  logic        rc_mode;
  logic        pin_change_wake;
  logic        bod_hold;
  logic        wdt_live;
  logic        tick;
  logic [4:0]  wake_raw;

  assign rc_mode  = cfg.oscillator_select_hi & cfg.oscillator_select_lo; // R13
  assign wake_raw = {wake_slow_pin, wake_pins}; // R5
  assign bod_hold = ~second_option_register_q[OPT_BOD_BIT] & brownout_detect; // R7
  assign wdt_live = cfg.wdt_fuse | second_option_register_q[OPT_SWDT_BIT]; // R9 R11
  assign pin_change_wake = (state_q == WRC_SLEEP) && second_option_register_q[OPT_PCW_BIT] // R20 R6
                           && (wake_flt_q != wake_lat_q); // R2

  ////////////////////////////////////////////////////////////////////////////
  // glitch filters: level must hold FILT cycles before accepted
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_filt
      logic [7:0] cnt_q;
      logic       raw;
      logic       out_q;
      if (gi < 5) begin : g_w
        assign raw = wake_raw[gi];
      end else begin : g_m
        assign raw = external_reset_pin_n;
      end
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q <= 8'h00;
          out_q <= (gi == 5) ? 1'b1 : 1'b0;
        end else if (raw == out_q) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= 8'(FILT - 1)) begin // R16
          cnt_q <= 8'h00;
          out_q <= raw;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
      if (gi < 5) begin : g_wo
        assign wake_flt_q[gi] = out_q;
      end else begin : g_mo
        assign external_reset_pin_flt_q = out_q;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sleep / reset sequencing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= WRC_HOLD;
      drt_cnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        WRC_RUN: begin
          if (!external_reset_pin_flt_q || bod_hold || (watchdog_timeout && wdt_live)) begin
            state_q   <= WRC_HOLD;
            drt_cnt_q <= 32'h0000_0000;
          end else if (sleep_req) begin
            state_q <= WRC_SLEEP;
          end
        end
        WRC_SLEEP: begin
          if (!external_reset_pin_flt_q || bod_hold || pin_change_wake // R3
              || (watchdog_timeout && wdt_lat_q)) begin
            state_q   <= WRC_HOLD;
            drt_cnt_q <= 32'h0000_0000;
          end
        end
        WRC_HOLD: begin
          if (!external_reset_pin_flt_q || bod_hold) begin // R7
            drt_cnt_q <= 32'h0000_0000;
          end else if (drt_cnt_q >= (rc_mode ? DRT_RC - 1 : DRT_STD - 1)) begin // R13 R14
            state_q <= WRC_RUN;
          end else begin
            drt_cnt_q <= drt_cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= WRC_HOLD;
        end
      endcase
    end
  end

  // wake levels and watchdog setting captured on sleep entry
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_lat_q <= 5'h00;
      wdt_lat_q  <= 1'b0;
    end else if (state_q == WRC_RUN && sleep_req) begin
      wake_lat_q <= wake_flt_q; // R1
      wdt_lat_q  <= wdt_live; // R10
    end
  end

  // cause flag: cleared by pin wake, set by any other reset cause
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_change_wake_flag_q <= 1'b1;
      wdt_cause_q            <= 1'b0;
    end else if (pin_change_wake) begin
      pin_change_wake_flag_q <= 1'b0; // R4
      wdt_cause_q            <= 1'b0;
    end else if (state_q != WRC_HOLD && watchdog_timeout
                 && (state_q == WRC_SLEEP ? wdt_lat_q : wdt_live)) begin
      pin_change_wake_flag_q <= 1'b1;
      wdt_cause_q            <= 1'b1;
    end else if (!external_reset_pin_flt_q || bod_hold) begin
      pin_change_wake_flag_q <= 1'b1;
      wdt_cause_q            <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      second_option_register_q  <= SECOND_OPTION_REGISTER_RST; // R8 R12
      prescale_q <= PRESCALE_RST;
    end else if (req.wr && req.addr == OFS_SECOND_OPTION_REGISTER) begin
      second_option_register_q <= req.wdata;
    end else if (req.wr && req.addr == OFS_PRESCALE) begin
      prescale_q <= req.wdata[2:0]; // R18
    end
  end

  // timer: software write wins, else counts on prescaler tick
  assign tick = (pre_cnt_q == ((10'h001 << (3'(prescale_q) + FIRST_SHIFT - 4'h1)) - 10'h001)); // R18
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_q             <= 10'h000;
      timer_zero_register_q <= 8'h00;
    end else if (req.wr && req.addr == OFS_TIMER) begin
      pre_cnt_q             <= 10'h000;
      timer_zero_register_q <= req.wdata; // R19
    end else if (tick) begin
      pre_cnt_q             <= 10'h000;
      timer_zero_register_q <= timer_zero_register_q + 8'h01;
    end else begin
      pre_cnt_q <= pre_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        OFS_SECOND_OPTION_REGISTER:  rdata <= second_option_register_q;
        OFS_STATUS:   rdata <= {5'h00, wdt_cause_q, pin_change_wake_flag_q, rc_mode};
        OFS_TIMER:    rdata <= timer_zero_register_q;
        OFS_PRESCALE: rdata <= {5'h00, prescale_q};
        OFS_CONTROL:  rdata <= {6'h00, state_q};
        default:      rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_reset_n             <= 1'b0;
      asleep                   <= 1'b0;
      watchdog_enable          <= 1'b0;
      sleep_low_voltage_select <= 1'b0;
      clock_output_pin         <= 1'b0;
    end else begin
      core_reset_n             <= (state_q != WRC_HOLD); // R3 R7
      asleep                   <= (state_q == WRC_SLEEP);
      watchdog_enable          <= (state_q == WRC_SLEEP) ? wdt_lat_q : wdt_live; // R9 R10 R11
      sleep_low_voltage_select <= (state_q == WRC_SLEEP) && second_option_register_q[OPT_SL_BIT]; // R15
      clock_output_pin         <= rc_mode & timer_zero_register_q[0]; // R17 R19
    end
  end

endmodule : wrc_top

/* wrc_pins.sv */
// Purpose: pin side model for wrc_top
// Assumes: levels change just after an edge
// Notes:   bits {brown-out, reset_n, slow, wake[3:0]}
`timescale 1ns/1ps
module wrc_pins (
  input  wire logic       clock,
  output logic [3:0]      wake_pins,
  output logic            wake_slow_pin,
  output logic            external_reset_pin_n,
  output logic            brownout_detect
);
  logic [6:0] p_q = 7'h20;
  assign {brownout_detect, external_reset_pin_n, wake_slow_pin, wake_pins} = p_q;
  // flip masked pins, then let n edges pass
  task automatic flip(input logic [6:0] m, input int n);
    @(posedge clock) p_q <= p_q ^ m;
    repeat (n) @(posedge clock);
    #1;
  endtask : flip
endmodule : wrc_pins

/* wrc_chk.sv */
// Purpose: port checker for wrc_top
// Assumes: second_option_register shadowed from bus writes
// Notes:   bound at the foot
`timescale 1ns/1ps
module wrc_chk
  import wrc_pkg::*;
#(
  parameter int unsigned DRT_RC  = DRT_RC_CYC,
  parameter int unsigned DRT_STD = DRT_STD_CYC,
  parameter int unsigned FILT    = FILT_CYC
) (
  input wire logic     clock,
  input wire logic     arst_n,
  input wire wrc_req_t req,
  input wire wrc_cfg_t cfg,
  input wire logic     sleep_req,
  input wire logic     external_reset_pin_n,
  input wire logic     brownout_detect,
  input wire logic     core_reset_n,
  input wire logic     asleep,
  input wire logic     watchdog_enable,
  input wire logic     sleep_low_voltage_select,
  input wire logic     clock_output_pin
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic [7:0]  opt_q;
  int unsigned lo_q;
  int unsigned drt;
  assign drt = (cfg.oscillator_select_hi && cfg.oscillator_select_lo) ? DRT_RC : DRT_STD;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) opt_q <= SECOND_OPTION_REGISTER_RST;
    else if (req.wr && req.addr == OFS_SECOND_OPTION_REGISTER) opt_q <= req.wdata;
  end
  // low span of core reset, restarted while a held cause is present
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) lo_q <= 0;
    else if (core_reset_n || brownout_detect || !external_reset_pin_n) lo_q <= 0;
    else lo_q <= lo_q + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_bod;
    brownout_detect && !opt_q[OPT_BOD_BIT] |-> ##[1:3] !core_reset_n;
  endproperty
  a_bod: assert property (p_bod) else $error("brown-out no reset");
  property p_fuse;
    cfg.wdt_fuse |=> watchdog_enable;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse no watchdog");
  property p_slv;
    !asleep && !$past(asleep) |-> !sleep_low_voltage_select;
  endproperty
  a_slv: assert property (p_slv) else $error("low voltage while awake");
  property p_clk;
    !(cfg.oscillator_select_hi && cfg.oscillator_select_lo) |=> !clock_output_pin;
  endproperty
  a_clk: assert property (p_clk) else $error("clock out outside rc");
  property p_wake;
    $fell(asleep) |-> ##[0:2] !core_reset_n;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without reset");
  property p_drt;
    $rose(core_reset_n) |-> lo_q + 1 >= drt && lo_q <= drt + FILT + 4;
  endproperty
  a_drt: assert property (p_drt) else $error("start-up delay wrong");
  property p_nap;
    sleep_req && !asleep && core_reset_n |-> ##[1:2] asleep;
  endproperty
  a_nap: assert property (p_nap) else $error("sleep not entered");
  property p_run;
    core_reset_n && !asleep && !$past(asleep) && external_reset_pin_n && !brownout_detect |=> core_reset_n;
  endproperty
  a_run: assert property (p_run) else $error("reset while running");
endmodule : wrc_chk

bind wrc_top wrc_chk #(.DRT_RC(DRT_RC), .DRT_STD(DRT_STD), .FILT(FILT)) wrc_chk_i (.clock, .arst_n, .req,
  .cfg, .sleep_req, .external_reset_pin_n, .brownout_detect, .core_reset_n, .asleep, .watchdog_enable,
  .sleep_low_voltage_select, .clock_output_pin);

/* wrc_top_bench.sv */
// Purpose: self-checking bench for wrc_top
// Assumes: short start-up counts
// Notes:   pins come from wrc_pins
`timescale 1ns/1ps
module wrc_top_bench;
  import wrc_pkg::*;
  localparam int unsigned RC  = 20;
  localparam int unsigned STD = 50;
  logic       clock, arst_n, sleep_req, wd_to, core_reset_n, asleep, wd_en, slv, clk_out, ext_n, bod, slow;
  logic [3:0] pins;
  logic [7:0] rdata, got;
  wrc_req_t   req;
  wrc_cfg_t   cfg;
  int         n_mismatch, checks_done, b;
  wrc_top #(.DRT_RC(RC), .DRT_STD(STD), .FILT(FILT_CYC)) wrc_top_i (.clock, .arst_n, .req, .rdata, .cfg,
    .sleep_req, .wake_pins(pins), .wake_slow_pin(slow), .external_reset_pin_n(ext_n), .brownout_detect(bod),
    .watchdog_timeout(wd_to), .core_reset_n, .asleep, .watchdog_enable(wd_en),
    .sleep_low_voltage_select(slv), .clock_output_pin(clk_out));
  wrc_pins wrc_pins_i (.clock, .wake_pins(pins), .wake_slow_pin(slow), .external_reset_pin_n(ext_n),
    .brownout_detect(bod));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #80000;
    n_mismatch++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic f(input logic [6:0] m, input int n);
    wrc_pins_i.flip(m, n);
  endtask : f
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req <= '0;
    #1 got = rdata;
  endtask : rd
  task automatic up;
    for (int i = 0; i < STD + 40 && core_reset_n !== 1'b1; i++) cyc(1);
    chk("core_up", 8'h01, 8'(core_reset_n));
  endtask : up
  task automatic boot(input wrc_cfg_t c);
    @(posedge clock) arst_n <= 1'b0;
    cfg <= c;
    cyc(2);
    @(posedge clock) arst_n <= 1'b1;
    up();
  endtask : boot
  task automatic nap;
    @(posedge clock) sleep_req <= 1'b1;
    @(posedge clock) sleep_req <= 1'b0;
    cyc(3);
    chk("asleep", 8'h01, 8'(asleep));
  endtask : nap
  task automatic t_regs;
    rd(OFS_SECOND_OPTION_REGISTER);
    chk("second_option_register", SECOND_OPTION_REGISTER_RST, got);
    f(7'h40, 10);
    chk("core_up", 8'h01, 8'(core_reset_n));
    f(7'h40, 0);
    wr(OFS_SECOND_OPTION_REGISTER, 8'h00);
    f(7'h40, 10);
    chk("core_up", 8'h00, 8'(core_reset_n));
    f(7'h40, 0);
    up();
  endtask : t_regs
  task automatic t_wake(input int k);
    wr(OFS_SECOND_OPTION_REGISTER, 8'h0C);
    f(7'h01 << k, 8);
    chk("core_up", 8'h01, 8'(core_reset_n));
    nap();
    f(7'h01 << k, 2);
    f(7'h01 << k, 6);
    chk("asleep", 8'h01, 8'(asleep));
    f(7'h01 << k, 8);
    chk("core_up", 8'h00, 8'(core_reset_n));
    up();
    rd(OFS_STATUS);
    chk("wake_flag", 8'h00, 8'(got[1]));
  endtask : t_wake
  task automatic t_off;
    wr(OFS_SECOND_OPTION_REGISTER, 8'h0A);
    nap();
    chk("slv", 8'h01, 8'(slv));
    f(7'h01, 8);
    f(7'h20, 2);
    f(7'h20, 6);
    chk("asleep", 8'h01, 8'(asleep));
    f(7'h20, 10);
    chk("core_up", 8'h00, 8'(core_reset_n));
    f(7'h20, 0);
    up();
    rd(OFS_STATUS);
    chk("wake_flag", 8'h01, 8'(got[1]));
  endtask : t_off
  task automatic t_misc;
    chk("wd_en", 8'h00, 8'(wd_en));
    wr(OFS_SECOND_OPTION_REGISTER, 8'h18);
    cyc(2);
    chk("wd_en", 8'h01, 8'(wd_en));
    wr(OFS_PRESCALE, 8'h07);
    rd(OFS_PRESCALE);
    chk("prescale", 8'h07, got);
    wr(OFS_TIMER, 8'h01);
    cyc(2);
    chk("clk_out", 8'h01, 8'(clk_out));
    wr(OFS_TIMER, 8'h00);
    cyc(2);
    chk("clk_out", 8'h00, 8'(clk_out));
  endtask : t_misc
  // software enable dropped in sleep, latched copy still fires
  task automatic t_wdt;
    nap();
    wr(OFS_SECOND_OPTION_REGISTER, 8'h08);
    cyc(2);
    chk("wd_en", 8'h01, 8'(wd_en));
    rd(OFS_CONTROL);
    chk("state", 8'h01, got);
    @(posedge clock) wd_to <= 1'b1;
    @(posedge clock) wd_to <= 1'b0;
    cyc(2);
    chk("core_up", 8'h00, 8'(core_reset_n));
    up();
    chk("wd_en", 8'h00, 8'(wd_en));
    rd(OFS_STATUS);
    chk("status", 8'h07, got);
  endtask : t_wdt
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    req = '0;
    sleep_req = 1'b0;
    wd_to = 1'b0;
    arst_n = 1'b0;
    cfg = 3'b110;
    boot(3'b110);
    t_regs();
    for (b = 0; b < 5; b++) t_wake(b);
    t_off();
    t_misc();
    t_wdt();
    boot(3'b001);
    chk("wd_en", 8'h01, 8'(wd_en));
    chk("clk_out", 8'h00, 8'(clk_out));
    summarize();
  end
endmodule : wrc_top_bench
